// >>> dlic_pkg.sv
// Constants and types shared by the drive logic input control block
`default_nettype none
package dlic_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SP_W = 16;
   localparam int NC = 8;
   localparam int REP_W = 24;
   localparam int DEB_W = 20;
   localparam int GATE_W = 24;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_JOG = 8'h04;
   localparam logic [7:0] REG_RATE = 8'h08;
   localparam logic [7:0] REG_PRESET0 = 8'h0C;
   localparam logic [7:0] REG_PRESET3 = 8'h18;
   localparam logic [7:0] REG_STATUS = 8'h1C;
   localparam logic [7:0] REG_LEAD = 8'h20;
   localparam logic [7:0] REG_FB = 8'h24;
   localparam logic [7:0] REG_DRIVE = 8'h28;

   // Contact index within the closure vector
   localparam int C_RUN = 0;
   localparam int C_JOG = 1;
   localparam int C_RSTOP = 2;
   localparam int C_FSTOP = 3;
   localparam int C_MODE = 4;
   localparam int C_PRESEL = 5;
   localparam int C_INC = 6;
   localparam int C_SHARED = 7;

   localparam logic [1:0] ROLE_DEC = 2'h1;
   localparam logic [1:0] ROLE_LOOP = 2'h2;
   localparam logic [1:0] ALLOC_NONE = 2'h0;
   localparam logic [1:0] ALLOC_FREQ = 2'h1;
   localparam logic [1:0] ALLOC_SETPT = 2'h2;
   localparam logic [1:0] ALLOC_OFFSET = 2'h3;

   localparam logic [15:0] SPEED_FULL = 16'hFFFF;
   localparam logic [15:0] RATE_RST = 16'h0001;
   localparam logic [15:0] JOG_RST = 16'h0000;
   localparam logic [15:0] PRESET_RST = 16'h0000;
   localparam int RATIO_SHIFT = 8;
   localparam int GAIN_SHIFT = 2;

   // Timing: clock period in ns, times in ms
   localparam int CLK_NS = 100;
   localparam int NS_PER_MS = 1000000;
   localparam int DEB_MS = 10;
   localparam int REPEAT_MS = 500;
   localparam int GATE_MS = 100;
   localparam int DEB_CYC_DEF = DEB_MS * (NS_PER_MS / CLK_NS);
   localparam int REPEAT_CYC_DEF = REPEAT_MS * (NS_PER_MS / CLK_NS);
   localparam int GATE_CYC_DEF = GATE_MS * (NS_PER_MS / CLK_NS);

   typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_JOG, ST_RSTOP, ST_FSTOP} dlic_state_e;

   typedef struct packed {
      logic [1:0] alloc;
      logic [1:0] role;
   } dlic_ctrl_s;

   localparam dlic_ctrl_s CTRL_RST = '{alloc: ALLOC_NONE, role: ROLE_DEC};
endpackage
`default_nettype wire

// >>> dlic_top.sv
// Contact and pulse input control logic of a DC motor speed drive
//
// Operation
// - Momentary run closure latches running state
// - Run refused unless both stops closed
// - Jog runs only while contact held
// - Jog needs stops closed, run open
// - Ramped stop opening latches ramped deceleration
// - Fast stop opening zeroes speed immediately
// - Mode input open master, closed follower
// - Mode and choice input pick preset
// - Increment closure raises setpoint one unit
// - Held increment repeats every half second
// - Role setting: decrement or loop type
// - Decrement closure lowers setpoint one unit
// - Held decrement repeats every half second
// - Closed loop drives error to zero
// - Open loop follows setpoint, ignores feedback
// - Lost feedback in closed loop commands full speed output while the speed command is nonzero
// - Measure lead pulse train speed
// - Measure feedback pulse train speed
// - Allocation routes analog input
`default_nettype none
module dlic_top #(
   parameter int DEB_CYC = dlic_pkg::DEB_CYC_DEF,
   parameter int REPEAT_CYC = dlic_pkg::REPEAT_CYC_DEF,
   parameter int GATE_CYC = dlic_pkg::GATE_CYC_DEF
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [31:0] rdata_o,
   // Contacts, low while closed to common
   input wire logic run_n_i,
   input wire logic jog_n_i,
   input wire logic rstop_n_i,
   input wire logic fstop_n_i,
   input wire logic mode_n_i,
   input wire logic presel_n_i,
   input wire logic inc_n_i,
   input wire logic shared_n_i,
   // Pulse trains and analog sample
   input wire logic lead_pulse_i,
   input wire logic fb_pulse_i,
   input wire logic [15:0] analog_i,
   // Drive side
   output logic [15:0] speed_cmd_o,
   output logic [15:0] drive_o,
   output logic running_o,
   output logic jog_active_o,
   output logic follower_o,
   output logic closed_loop_o,
   output logic fb_lost_o,
   output logic full_speed_hazard_o
);
   typedef logic [15:0] dlic_val_t;

   function automatic dlic_val_t sat_step(input dlic_val_t v, input logic up);
      if (up) begin
         sat_step = (v == dlic_pkg::SPEED_FULL) ? v : v + 16'h0001;
      end else begin
         sat_step = (v == 16'h0000) ? v : v - 16'h0001;
      end
   endfunction

   function automatic dlic_val_t clamp_s(input logic signed [18:0] v);
      if (v < 19'sh00000) begin
         clamp_s = 16'h0000;
      end else if (v > 19'sh0FFFF) begin
         clamp_s = dlic_pkg::SPEED_FULL;
      end else begin
         clamp_s = v[15:0];
      end
   endfunction

   // Contact synchronisers and debouncers
   logic [7:0] s1_q, s2_q, s3_q, closed_q, prev_q;
   logic [19:0] deb_q [8];
   wire logic [7:0] pins = {shared_n_i, inc_n_i, presel_n_i, mode_n_i,
                            fstop_n_i, rstop_n_i, jog_n_i, run_n_i};

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s1_q <= 8'hFF;
         s2_q <= 8'hFF;
         s3_q <= 8'hFF;
      end else if (ce_i) begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change must hold for DEB_CYC cycles; stop openings shorter than that are bounce
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         closed_q <= 8'h00;
         prev_q <= 8'h00;
         for (int i = 0; i < dlic_pkg::NC; i++) deb_q[i] <= 20'h00000;
      end else if (ce_i) begin
         prev_q <= closed_q;
         for (int i = 0; i < dlic_pkg::NC; i++) begin
            if (s2_q[i] == s3_q[i] && s2_q[i] == closed_q[i]) begin
               if (deb_q[i] == 20'(DEB_CYC - 1)) begin
                  closed_q[i] <= ~s2_q[i];
                  deb_q[i] <= 20'h00000;
               end else begin
                  deb_q[i] <= deb_q[i] + 20'h00001;
               end
            end else begin
               deb_q[i] <= 20'h00000;
            end
         end
      end
   end

   wire logic [7:0] rise = closed_q & ~prev_q;
   wire logic stops_ok = closed_q[dlic_pkg::C_RSTOP] & closed_q[dlic_pkg::C_FSTOP];
   wire logic run_rise = rise[dlic_pkg::C_RUN] & stops_ok;
   wire logic jog_ok = closed_q[dlic_pkg::C_JOG] & ~closed_q[dlic_pkg::C_RUN]
                       & stops_ok;

   // Run / jog / stop state
   dlic_pkg::dlic_state_e st_q, st_d;

   always_comb begin
      st_d = st_q;
      case (st_q)
         dlic_pkg::ST_RUN: st_d = st_q;
         dlic_pkg::ST_JOG: begin
            if (!closed_q[dlic_pkg::C_JOG]) st_d = dlic_pkg::ST_IDLE;
         end
         default: begin
            if (run_rise) begin
               st_d = dlic_pkg::ST_RUN;
            end else if (jog_ok) begin
               st_d = dlic_pkg::ST_JOG;
            end
         end
      endcase
      if (!closed_q[dlic_pkg::C_FSTOP]) begin
         st_d = dlic_pkg::ST_FSTOP;
      end else if (!closed_q[dlic_pkg::C_RSTOP] && st_q != dlic_pkg::ST_FSTOP) begin
         st_d = dlic_pkg::ST_RSTOP;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) st_q <= dlic_pkg::ST_IDLE;
      else if (ce_i) st_q <= st_d;
   end

   // Registers
   dlic_pkg::dlic_ctrl_s ctrl_q;
   dlic_val_t jog_q, rate_q;
   dlic_val_t preset_q [4];
   wire logic follower = closed_q[dlic_pkg::C_MODE];
   wire logic [1:0] idx = {follower, closed_q[dlic_pkg::C_PRESEL]};
   wire logic dec_en = ctrl_q.role == dlic_pkg::ROLE_DEC;
   wire logic loop_en = ctrl_q.role == dlic_pkg::ROLE_LOOP;
   wire logic open_loop = loop_en & closed_q[dlic_pkg::C_SHARED];
   wire logic pre_wr = we_i && addr_i >= dlic_pkg::REG_PRESET0
                       && addr_i <= dlic_pkg::REG_PRESET3 && addr_i[1:0] == 2'h0;
   // Cut after the shift: a narrow cut before it would drop the index bits
   wire logic [1:0] pre_idx = 2'(8'(addr_i - dlic_pkg::REG_PRESET0) >> 2);

   // Scroll auto-repeat: first step on closure, then one per REPEAT_CYC while held
   logic [23:0] rep_q [2];
   logic [1:0] rep_hit;
   wire logic [1:0] held = {closed_q[dlic_pkg::C_SHARED] & dec_en,
                            closed_q[dlic_pkg::C_INC]};

   always_comb begin
      for (int k = 0; k < 2; k++) begin
         rep_hit[k] = held[k] && rep_q[k] == 24'(REPEAT_CYC - 1);
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rep_q[0] <= 24'h000000;
         rep_q[1] <= 24'h000000;
      end else if (ce_i) begin
         for (int k = 0; k < 2; k++) begin
            if (!held[k] || rep_hit[k]) rep_q[k] <= 24'h000000;
            else rep_q[k] <= rep_q[k] + 24'h000001;
         end
      end
   end

   wire logic step_up = rise[dlic_pkg::C_INC] | rep_hit[0];
   wire logic step_dn = dec_en & (rise[dlic_pkg::C_SHARED] | rep_hit[1]);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_q <= dlic_pkg::CTRL_RST;
         jog_q <= dlic_pkg::JOG_RST;
         rate_q <= dlic_pkg::RATE_RST;
         for (int p = 0; p < 4; p++) preset_q[p] <= dlic_pkg::PRESET_RST;
      end else if (ce_i) begin
         if (we_i && addr_i == dlic_pkg::REG_CTRL) ctrl_q <= wdata_i[3:0];
         if (we_i && addr_i == dlic_pkg::REG_JOG) jog_q <= wdata_i[15:0];
         if (we_i && addr_i == dlic_pkg::REG_RATE) rate_q <= wdata_i[15:0];
         // A software write to the active preset wins over a scroll step
         if (pre_wr) begin
            preset_q[pre_idx] <= wdata_i[15:0];
         end
         if (!(pre_wr && pre_idx == idx) && step_up != step_dn) begin
            preset_q[idx] <= sat_step(preset_q[idx], step_up);
         end
      end
   end

   // Pulse train measurement: edges counted over a gate window
   logic [1:0] p1_q, p2_q, p3_q, plev_q;
   logic [15:0] acc_q [2];
   logic [15:0] lead_cnt_q, fb_cnt_q;
   logic [23:0] gate_q;
   logic fb_lost_q;
   wire logic gate_end = gate_q == 24'(GATE_CYC - 1);
   wire logic [1:0] pedge = p2_q & p3_q & ~plev_q;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         p1_q <= 2'h0;
         p2_q <= 2'h0;
         p3_q <= 2'h0;
         plev_q <= 2'h0;
         gate_q <= 24'h000000;
         acc_q[0] <= 16'h0000;
         acc_q[1] <= 16'h0000;
         lead_cnt_q <= 16'h0000;
         fb_cnt_q <= 16'h0000;
         fb_lost_q <= 1'b0;
      end else if (ce_i) begin
         p1_q <= {fb_pulse_i, lead_pulse_i};
         p2_q <= p1_q;
         p3_q <= p2_q;
         for (int k = 0; k < 2; k++) begin
            if (p2_q[k] == p3_q[k]) plev_q[k] <= p2_q[k];
            if (gate_end) acc_q[k] <= 16'(pedge[k]);
            else if (pedge[k]) acc_q[k] <= sat_step(acc_q[k], 1'b1);
         end
         gate_q <= gate_end ? 24'h000000 : gate_q + 24'h000001;
         if (gate_end) begin
            lead_cnt_q <= acc_q[0];
            fb_cnt_q <= acc_q[1];
            fb_lost_q <= acc_q[1] == 16'h0000;
         end
      end
   end

   // Setpoint, analog routing and target speed
   wire logic [1:0] alloc = ctrl_q.alloc;
   wire dlic_val_t sp = (alloc == dlic_pkg::ALLOC_SETPT) ? analog_i : preset_q[idx];
   wire dlic_val_t lead_v = (alloc == dlic_pkg::ALLOC_FREQ) ? analog_i : lead_cnt_q;
   wire logic [31:0] ratio = lead_v * sp;
   wire dlic_val_t fol = ratio[dlic_pkg::RATIO_SHIFT +: 16];
   wire dlic_val_t ofs = (alloc == dlic_pkg::ALLOC_OFFSET) ? analog_i : 16'h0000;
   wire dlic_val_t fol_sp = clamp_s(19'(fol) + 19'(ofs));
   dlic_val_t target;

   always_comb begin
      target = 16'h0000;
      case (st_q)
         dlic_pkg::ST_RUN: target = follower ? fol_sp : sp;
         dlic_pkg::ST_JOG: target = jog_q;
         default: target = 16'h0000;
      endcase
   end

   // Speed ramp and drive output
   dlic_val_t speed_q, speed_d, drive_q, drive_d;
   wire logic signed [18:0] up_s = 19'(speed_q) + 19'(rate_q);
   wire logic signed [18:0] dn_s = 19'(speed_q) - 19'(rate_q);
   wire logic signed [18:0] err = 19'(speed_q) - 19'(fb_cnt_q);
   wire logic hazard = fb_lost_q & ~open_loop & speed_q != 16'h0000;

   always_comb begin
      if (st_q == dlic_pkg::ST_FSTOP) begin
         speed_d = 16'h0000;
      end else if (speed_q < target) begin
         speed_d = (up_s > 19'(target)) ? target : clamp_s(up_s);
      end else if (speed_q > target) begin
         speed_d = (dn_s < $signed(19'(target))) ? target : clamp_s(dn_s);
      end else begin
         speed_d = speed_q;
      end
      // Hazard kept on purpose: lost feedback in closed loop runs flat out
      if (hazard) begin
         drive_d = dlic_pkg::SPEED_FULL;
      end else if (open_loop || speed_q == 16'h0000) begin
         drive_d = speed_q;
      end else begin
         drive_d = clamp_s(19'(drive_q) + (err >>> dlic_pkg::GAIN_SHIFT));
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         speed_q <= 16'h0000;
         drive_q <= 16'h0000;
      end else if (ce_i) begin
         speed_q <= speed_d;
         drive_q <= drive_d;
      end
   end

   // Read port
   logic [31:0] rdata_q;
   wire logic [31:0] status = {17'h00000, fb_lost_q, open_loop, follower,
                               4'(st_q), closed_q};
   logic [31:0] rd_mux;

   always_comb begin
      if (addr_i == dlic_pkg::REG_CTRL) rd_mux = 32'(ctrl_q);
      else if (addr_i == dlic_pkg::REG_JOG) rd_mux = 32'(jog_q);
      else if (addr_i == dlic_pkg::REG_RATE) rd_mux = 32'(rate_q);
      else if (pre_wr || (addr_i >= dlic_pkg::REG_PRESET0
               && addr_i <= dlic_pkg::REG_PRESET3 && addr_i[1:0] == 2'h0))
         rd_mux = 32'(preset_q[pre_idx]);
      else if (addr_i == dlic_pkg::REG_STATUS) rd_mux = status;
      else if (addr_i == dlic_pkg::REG_LEAD) rd_mux = 32'(lead_cnt_q);
      else if (addr_i == dlic_pkg::REG_FB) rd_mux = 32'(fb_cnt_q);
      else if (addr_i == dlic_pkg::REG_DRIVE) rd_mux = 32'(drive_q);
      else rd_mux = 32'h00000000;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) rdata_q <= 32'h00000000;
      else if (ce_i) rdata_q <= re_i ? rd_mux : 32'h00000000;
   end

   assign rdata_o = rdata_q;
   assign speed_cmd_o = speed_q;
   assign drive_o = drive_q;
   assign running_o = st_q == dlic_pkg::ST_RUN;
   assign jog_active_o = st_q == dlic_pkg::ST_JOG;
   assign follower_o = follower;
   assign closed_loop_o = ~open_loop;
   assign fb_lost_o = fb_lost_q;
   assign full_speed_hazard_o = hazard;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   wire logic idle_like = st_q != dlic_pkg::ST_RUN && st_q != dlic_pkg::ST_JOG;

   property p_run_latch;
      ce_i && run_rise && idle_like |=> st_q == dlic_pkg::ST_RUN;
   endproperty
   a_run_latch: assert property (p_run_latch) else $error("run not latched");

   property p_run_refused;
      ce_i && rise[dlic_pkg::C_RUN] && !stops_ok |=> st_q != dlic_pkg::ST_RUN;
   endproperty
   a_run_refused: assert property (p_run_refused) else $error("run taken with stop open");

   property p_jog_release;
      ce_i && st_q == dlic_pkg::ST_JOG && !closed_q[dlic_pkg::C_JOG]
         |=> st_q != dlic_pkg::ST_JOG;
   endproperty
   a_jog_release: assert property (p_jog_release) else $error("jog held after open");

   property p_jog_refused;
      ce_i && closed_q[dlic_pkg::C_RUN] && st_q != dlic_pkg::ST_JOG
         |=> st_q != dlic_pkg::ST_JOG;
   endproperty
   a_jog_refused: assert property (p_jog_refused) else $error("jog with run closed");

   property p_rstop;
      ce_i && !closed_q[dlic_pkg::C_RSTOP] && closed_q[dlic_pkg::C_FSTOP]
         && st_q != dlic_pkg::ST_FSTOP |=> st_q == dlic_pkg::ST_RSTOP;
   endproperty
   a_rstop: assert property (p_rstop) else $error("ramped stop not latched");

   property p_fstop;
      ce_i && !closed_q[dlic_pkg::C_FSTOP] ##1 ce_i |=> speed_q == 16'h0000 && !running_o;
   endproperty
   a_fstop: assert property (p_fstop) else $error("fast stop speed not zero");

   property p_inc;
      ce_i && step_up && !step_dn && !pre_wr && sp != dlic_pkg::SPEED_FULL
         && alloc != dlic_pkg::ALLOC_SETPT
         |=> preset_q[$past(idx)] == $past(preset_q[idx]) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc) else $error("increment missed");

   property p_dec;
      ce_i && step_dn && !step_up && !pre_wr && preset_q[idx] != 16'h0000
         |=> preset_q[$past(idx)] == $past(preset_q[idx]) - 16'h0001;
   endproperty
   a_dec: assert property (p_dec) else $error("decrement missed");

   property p_hazard;
      ce_i && fb_lost_q && !open_loop && speed_q != 16'h0000 |=> drive_q == dlic_pkg::SPEED_FULL;
   endproperty
   a_hazard: assert property (p_hazard) else $error("lost feedback not full");

   property p_open_loop;
      ce_i && open_loop |=> drive_q == $past(speed_q);
   endproperty
   a_open_loop: assert property (p_open_loop) else $error("open loop used feedback");

   c_run: cover property (ce_i && st_q == dlic_pkg::ST_RUN && speed_q != 16'h0000);
   c_jog: cover property (ce_i && st_q == dlic_pkg::ST_JOG);
   c_fstop: cover property (ce_i && st_q == dlic_pkg::ST_FSTOP && $past(running_o));
   c_repeat: cover property (ce_i && rep_hit[0]);
endmodule
`default_nettype wire

// >>> dlic_contacts.sv
// Model of the operator switches, relay contacts and pulse sensors
`default_nettype none
module dlic_contacts (
   // Clock
   input wire logic clk_i,
   // Contacts, low while closed to common
   output logic [7:0] contact_n_o,
   // Pulse trains from the lead and follower sensors
   output logic lead_pulse_o,
   output logic fb_pulse_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Periods in clock cycles; zero stops a train, as a lost sensor would
   int lead_per = 0;
   int fb_per = 0;
   int tick = 0;

   // Open contacts read high through the input pull-ups
   initial begin
      contact_n_o = 8'hFF;
      lead_pulse_o = 1'b0;
      fb_pulse_o = 1'b0;
   end

   always @(posedge clk_i) begin
      tick <= tick + 1;
      // Half-period high time, so a pulse outlasts the input filter
      lead_pulse_o <= (lead_per == 0) ? 1'b0 : (tick % lead_per < lead_per / 2);
      fb_pulse_o <= (fb_per == 0) ? 1'b0 : (tick % fb_per < fb_per / 2);
   end

   // All contacts in the mask move together, so a double stop is truly simultaneous
   task automatic press(input logic [7:0] mask, input logic closed);
      @(posedge clk_i);
      contact_n_o <= closed ? (contact_n_o & ~mask) : (contact_n_o | mask);
   endtask

   task automatic hold(input logic [7:0] mask, input logic closed, input int n);
      press(mask, closed);
      repeat (n) @(posedge clk_i);
      press(mask, ~closed);
   endtask
endmodule
`default_nettype wire

// >>> dlic_bench.sv
// Self-checking bench for the drive logic input control block
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("MISMATCH %s expected %h seen %h", what, exp, got); \
      end \
   end
module dlic_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // Short counts keep the run brief; every timing expectation derives from them
   localparam int DEB = 4;
   localparam int REP = 20;
   localparam int GATE = 16;
   localparam logic [7:0] M_RUN = 8'h01 << dlic_pkg::C_RUN;
   localparam logic [7:0] M_JOG = 8'h01 << dlic_pkg::C_JOG;
   localparam logic [7:0] M_RST = 8'h01 << dlic_pkg::C_RSTOP;
   localparam logic [7:0] M_FST = 8'h01 << dlic_pkg::C_FSTOP;
   localparam logic [7:0] M_MODE = 8'h01 << dlic_pkg::C_MODE;
   localparam logic [7:0] M_PSEL = 8'h01 << dlic_pkg::C_PRESEL;
   localparam logic [7:0] M_INC = 8'h01 << dlic_pkg::C_INC;
   localparam logic [7:0] M_SHR = 8'h01 << dlic_pkg::C_SHARED;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h00000000;
   logic we_i = 1'b0;
   logic re_i = 1'b0;
   logic [31:0] rdata_o;
   logic [7:0] contact_n;
   logic lead_pulse, fb_pulse;
   logic [15:0] speed_cmd_o, drive_o;
   logic running_o, jog_active_o, follower_o, closed_loop_o, fb_lost_o, full_speed_hazard_o;
   int miscompares = 0;
   int comparisons = 0;
   logic [31:0] v;
   logic [15:0] s;
   logic [15:0] analog = 16'h0000;

   always #50 clk_i = ~clk_i;

   dlic_contacts ops (.clk_i(clk_i), .contact_n_o(contact_n), .lead_pulse_o(lead_pulse),
      .fb_pulse_o(fb_pulse));

   dlic_top #(.DEB_CYC(DEB), .REPEAT_CYC(REP), .GATE_CYC(GATE)) dut (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i),
      .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
      .run_n_i(contact_n[dlic_pkg::C_RUN]), .jog_n_i(contact_n[dlic_pkg::C_JOG]),
      .rstop_n_i(contact_n[dlic_pkg::C_RSTOP]), .fstop_n_i(contact_n[dlic_pkg::C_FSTOP]),
      .mode_n_i(contact_n[dlic_pkg::C_MODE]), .presel_n_i(contact_n[dlic_pkg::C_PRESEL]),
      .inc_n_i(contact_n[dlic_pkg::C_INC]), .shared_n_i(contact_n[dlic_pkg::C_SHARED]),
      .lead_pulse_i(lead_pulse), .fb_pulse_i(fb_pulse), .analog_i(analog),
      .speed_cmd_o(speed_cmd_o), .drive_o(drive_o), .running_o(running_o),
      .jog_active_o(jog_active_o), .follower_o(follower_o), .closed_loop_o(closed_loop_o),
      .fb_lost_o(fb_lost_o), .full_speed_hazard_o(full_speed_hazard_o));

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      we_i <= 1'b1;
      @(posedge clk_i);
      we_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      re_i <= 1'b1;
      @(posedge clk_i);
      re_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask

   // Sync stages plus debounce plus state update, with margin
   task automatic settle();
      repeat (DEB + 10) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic note(input string name);
      $display("Test %s done", name);
   endtask

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      $display("Watchdog expired");
      test_done();
   end

   initial begin
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd(dlic_pkg::REG_CTRL, v);
      `CHK("ctrl reset", 32'h00000001, v);
      rd(dlic_pkg::REG_RATE, v);
      `CHK("rate reset", 32'h00000001, v);
      wr(8'h40, 32'h0000FFFF);
      rd(8'h40, v);
      `CHK("unmapped", 32'h00000000, v);
      rd(dlic_pkg::REG_STATUS, v);
      `CHK("state after reset", 4'h4, v[11:8]);
      for (int k = 0; k < 4; k++) begin
         wr(8'(dlic_pkg::REG_PRESET0 + 4 * k), 32'(16'h0064 * (k + 1)));
      end
      note("registers");
      ops.press(M_RST, 1'b1);
      settle();
      ops.hold(M_RUN, 1'b1, 8);
      settle();
      `CHK("run refused", 1'b0, running_o);
      ops.press(M_FST, 1'b1);
      settle();
      ops.hold(M_RUN, 1'b1, 8);
      settle();
      `CHK("run latched", 1'b1, running_o);
      repeat (3 * GATE) @(posedge clk_i);
      @(negedge clk_i);
      `CHK("fb lost", 1'b1, fb_lost_o);
      `CHK("hazard", 1'b1, full_speed_hazard_o);
      `CHK("full drive", 16'hFFFF, drive_o);
      ops.lead_per <= 4;
      ops.fb_per <= 4;
      repeat (3 * GATE) @(posedge clk_i);
      rd(dlic_pkg::REG_LEAD, v);
      `CHK("lead count", 32'h00000004, v);
      rd(dlic_pkg::REG_FB, v);
      `CHK("fb count", 32'h00000004, v);
      note("run and pulses");
      ops.hold(M_RST, 1'b0, 2);
      settle();
      `CHK("bounce ignored", 1'b1, running_o);
      ops.hold(M_RST, 1'b0, 8);
      settle();
      `CHK("ramp stop", 1'b0, running_o);
      rd(dlic_pkg::REG_STATUS, v);
      `CHK("ramp state", 4'h3, v[11:8]);
      s = speed_cmd_o;
      @(negedge clk_i);
      `CHK("decel step", s - 16'h0001, speed_cmd_o);
      ops.hold(M_RUN, 1'b1, 8);
      repeat (30) @(posedge clk_i);
      ops.hold(M_FST, 1'b0, 8);
      settle();
      `CHK("fast stop speed", 16'h0000, speed_cmd_o);
      ops.hold(M_RUN, 1'b1, 8);
      settle();
      ops.hold(M_RST | M_FST, 1'b0, 8);
      settle();
      rd(dlic_pkg::REG_STATUS, v);
      `CHK("double stop", 5'h04, {running_o, v[11:8]});
      note("stops");
      ops.press(M_FST, 1'b0);
      ops.press(M_JOG, 1'b1);
      settle();
      `CHK("jog refused", 1'b0, jog_active_o);
      ops.press(M_JOG, 1'b0);
      ops.press(M_FST, 1'b1);
      settle();
      ops.press(M_JOG, 1'b1);
      settle();
      `CHK("jog held", 1'b1, jog_active_o);
      ops.press(M_JOG, 1'b0);
      settle();
      `CHK("jog released", 1'b0, jog_active_o);
      note("jog");
      for (int k = 0; k < 4; k++) begin
         ops.press(M_MODE, k[1]);
         ops.press(M_PSEL, k[0]);
         settle();
         `CHK("follower", k[1], follower_o);
         ops.hold(M_INC, 1'b1, 8);
         settle();
         rd(8'(dlic_pkg::REG_PRESET0 + 4 * k), v);
         `CHK("preset step up", 32'(16'h0064 * (k + 1) + 1), v);
      end
      // Held for 2.5 repeat periods: one step at closure and two repeats
      ops.hold(M_INC, 1'b1, 50);
      settle();
      rd(dlic_pkg::REG_PRESET3, v);
      `CHK("held up", 32'h00000194, v);
      ops.hold(M_SHR, 1'b1, 8);
      settle();
      rd(dlic_pkg::REG_PRESET3, v);
      `CHK("step down", 32'h00000193, v);
      ops.hold(M_SHR, 1'b1, 50);
      settle();
      rd(dlic_pkg::REG_PRESET3, v);
      `CHK("held down", 32'h00000190, v);
      note("setpoints");
      wr(dlic_pkg::REG_CTRL, 32'h0000000E);
      analog <= 16'h0020;
      rd(dlic_pkg::REG_CTRL, v);
      `CHK("ctrl alloc", 32'h0000000E, v);
      ops.fb_per <= 0;
      ops.press(M_SHR, 1'b1);
      settle();
      `CHK("open loop", 1'b0, closed_loop_o);
      ops.hold(M_RUN, 1'b1, 8);
      repeat (3 * GATE) @(posedge clk_i);
      @(negedge clk_i);
      `CHK("no hazard open", 2'b10, {fb_lost_o, full_speed_hazard_o});
      // Follower target: 4 lead edges times 0x190 over 256, plus offset 0x20
      `CHK("offset target", 16'h0026, speed_cmd_o);
      rd(dlic_pkg::REG_PRESET3, v);
      `CHK("loop role no step", 32'h00000190, v);
      ops.press(M_SHR, 1'b0);
      settle();
      `CHK("closed loop", 1'b1, closed_loop_o);
      note("loop");
      test_done();
   end
endmodule
`default_nettype wire
